// file: bench/dcc_channel_sva.sv
// Port-level assertions for the channel control block
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_channel_sva
  import dcc_pkg::*;
#(
  parameter int NUM_PERIPH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] bus_addr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic [NUM_PERIPH-1:0] periph_req,
  input wire logic buffer_end,
  input wire logic chan_active,
  input wire logic source_port_select,
  input wire logic destination_port_select,
  input wire dcc_flow_e flow_controller_select,
  input wire logic [3:0] source_peripheral_number,
  input wire logic [3:0] destination_peripheral_number,
  input wire logic source_handshake_select,
  input wire logic destination_handshake_select,
  input wire logic src_request,
  input wire logic dst_request,
  input wire dcc_fifo_e fifo_service_policy,
  input wire logic [3:0] bus_protection_attributes,
  input wire logic if_lock_enable,
  input wire logic bus_lock_enable,
  input wire logic arb_lock_buffer,
  input wire logic buffer_complete_flag,
  input wire logic done_writeback
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Strobes never overlap, so readback must equal the decoded levels one cycle on
  a_ctrl_b_fields: assert property (
    bus_rd && bus_addr == `DCC_OFF_CTRL_B |=> bus_rdata[0] == source_port_select
      && bus_rdata[4] == destination_port_select && bus_rdata[22:21] == flow_controller_select)
    else $error("control B outputs differ from readback");
  a_config_fields: assert property (
    bus_rd && bus_addr == `DCC_OFF_CONFIG |=> bus_rdata[7:0] == {destination_peripheral_number,
      source_peripheral_number} && bus_rdata[13] == destination_handshake_select
      && bus_rdata[9] == source_handshake_select && bus_rdata[22:20] == {arb_lock_buffer,
      bus_lock_enable, if_lock_enable} && bus_rdata[29:28] == fifo_service_policy
      && bus_rdata[26:24] == bus_protection_attributes[3:1])
    else $error("configuration outputs differ from readback");
  a_rdata_idle_zero: assert property (
    !$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_prot_data_bit: assert property (
    bus_protection_attributes[0] == 1'b1)
    else $error("data access attribute missing");
  a_done_pulse: assert property (
    buffer_end && chan_active |=> done_writeback)
    else $error("no done write-back after buffer end");
  a_idle_no_request: assert property (
    !chan_active |-> !src_request && !dst_request)
    else $error("request while channel inactive");
  // Two synchroniser flops put the chosen line two samples back
  a_hw_src_route: assert property (
    chan_active && source_handshake_select && !$past(sys_rst) && !$past(sys_rst, 2)
      && $past(source_peripheral_number, 2) == source_peripheral_number
      |-> src_request == $past(periph_req[source_peripheral_number], 2))
    else $error("source request not from its peripheral line");
  a_flag_cause: assert property (
    $rose(buffer_complete_flag) |-> $past(buffer_end && chan_active))
    else $error("complete flag set without buffer end");
endmodule
bind dcc_channel dcc_channel_sva #(.NUM_PERIPH(NUM_PERIPH)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .periph_req(periph_req), .buffer_end(buffer_end), .chan_active(chan_active),
  .source_port_select(source_port_select), .destination_port_select(destination_port_select),
  .flow_controller_select(flow_controller_select), .source_peripheral_number(source_peripheral_number),
  .destination_peripheral_number(destination_peripheral_number),
  .source_handshake_select(source_handshake_select), .destination_handshake_select(destination_handshake_select),
  .src_request(src_request), .dst_request(dst_request), .fifo_service_policy(fifo_service_policy),
  .bus_protection_attributes(bus_protection_attributes), .if_lock_enable(if_lock_enable),
  .bus_lock_enable(bus_lock_enable), .arb_lock_buffer(arb_lock_buffer),
  .buffer_complete_flag(buffer_complete_flag), .done_writeback(done_writeback)
);

// file: bench/dcc_periph_model.sv
// Peripheral request lines: one commanded line, all others toggling
`timescale 1ns/1ps
module dcc_periph_model #(
  parameter int NUM_PERIPH = 16
) (
  input wire logic clk,
  input wire logic [3:0] sel,
  input wire logic lvl,
  output logic [NUM_PERIPH-1:0] periph_req
);
  logic [NUM_PERIPH-1:0] noise = '0;
  // Lines move off the clock edge, as unsynchronised peripherals do
  always @(posedge clk)
  begin
    noise <= #3 ~noise;
  end
  // Neighbour noise shows up any misrouted request number
  always_comb
  begin
    periph_req = noise;
    periph_req[sel] = lvl;
  end
endmodule

// file: bench/tb.sv
// Self-checking bench for the channel control block
`timescale 1ns/1ps
`include "dcc_defines.svh"
module tb;
  import dcc_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, lvl = 1'b0;
  logic [31:0] bus_addr = '0, bus_wdata = '0, desc_src_addr = '0, desc_dst_addr = '0, r;
  logic xfer_src_done = 1'b0, xfer_dst_done = 1'b0, desc_load = 1'b0, desc_done_bit = 1'b0, buffer_end = 1'b0;
  logic [2:0] addr_step = 3'h4;
  logic [3:0] sel = 4'h0, spn, dpn;
  logic [15:0] periph_req;
  logic [31:0] bus_rdata, src_addr, dst_addr;
  logic [3:0] bus_protection_attributes;
  logic chan_active, sps, dps, shs, dhs, src_request, dst_request, ifl, bsl, arb, bcf, done_writeback;
  dcc_flow_e flow;
  dcc_fifo_e fifo;
  // Bench model of registers and addresses
  logic [31:0] ctrl_m = '0, cfg_m = '0, jmp_m[2], st_m[2], ma[2];
  logic act_m = 1'b0, wp_m = 1'b0;
  logic [1:0] ev_m = 2'h0;
  int cnt[2], seed = 32'h05aa5249, err_total = 0, samples_checked = 0, cyc = 0;
  dcc_channel dut_u (
    .clk(clk), .sys_rst(sys_rst), .ce(1'b1), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .periph_req(periph_req), .xfer_src_done(xfer_src_done),
    .xfer_dst_done(xfer_dst_done), .addr_step(addr_step), .desc_load(desc_load), .desc_src_addr(desc_src_addr),
    .desc_dst_addr(desc_dst_addr), .desc_done_bit(desc_done_bit), .buffer_end(buffer_end),
    .chan_active(chan_active), .src_addr(src_addr), .dst_addr(dst_addr), .source_port_select(sps),
    .destination_port_select(dps), .flow_controller_select(flow), .source_peripheral_number(spn),
    .destination_peripheral_number(dpn), .source_handshake_select(shs), .destination_handshake_select(dhs),
    .src_request(src_request), .dst_request(dst_request), .fifo_service_policy(fifo),
    .bus_protection_attributes(bus_protection_attributes), .if_lock_enable(ifl), .bus_lock_enable(bsl),
    .arb_lock_buffer(arb), .buffer_complete_flag(bcf), .done_writeback(done_writeback)
  );
  dcc_periph_model periph_u (.clk(clk), .sel(sel), .lvl(lvl), .periph_req(periph_req));
  // Clock and hang guard
  initial
  begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      close_out;
    end
  end
  task automatic close_out;
    $display("Compared %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Register write; the model applies the same refusal and masking
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    if (a == `DCC_OFF_CTRL_B && !wp_m) ctrl_m = d & `DCC_CTRL_B_MASK;
    if (a == `DCC_OFF_CONFIG && !wp_m) cfg_m = d & `DCC_CONFIG_MASK;
    if (a == `DCC_OFF_SRC_START) st_m[0] = d;
    if (a == `DCC_OFF_DST_START) st_m[1] = d;
    if (a == `DCC_OFF_SRC_JUMP) jmp_m[0] = d & `DCC_JUMP_MASK;
    if (a == `DCC_OFF_DST_JUMP) jmp_m[1] = d & `DCC_JUMP_MASK;
    if (a == `DCC_OFF_WP_MODE && d[31:8] == `DCC_WP_KEY) wp_m = d[0];
    if (a == `DCC_OFF_EVENT) ev_m = ev_m & ~d[1:0];
    // A start loads the addresses only from an idle channel
    if (a == `DCC_OFF_CHANNEL)
    begin
      if (d[0] && !act_m)
      begin
        ma = st_m;
        cnt = '{0, 0};
      end
      act_m = d[0];
    end
    @(posedge clk);
  endtask
  // Read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, exp);
    @(posedge clk);
  endtask
  task automatic mstep(input int s);
    logic [1:0] m;
    m = s ? ctrl_m[29:28] : ctrl_m[25:24];
    if (m == 2'h0) ma[s] = ma[s] + addr_step;
    if (m == 2'h1) ma[s] = ma[s] - addr_step;
    if (ctrl_m[8 + 4 * s] && jmp_m[s][25:16] != 0)
    begin
      cnt[s]++;
      if (cnt[s] == jmp_m[s][25:16])
      begin
        ma[s] = ma[s] + jmp_m[s][15:0];
        cnt[s] = 0;
      end
    end
  endtask
  // Engine event: 0 source transfer, 1 destination transfer, 2 descriptor, 3 buffer end
  task automatic ev(input int k);
    logic dwb;
    xfer_src_done <= (k == 0);
    xfer_dst_done <= (k == 1);
    desc_load <= (k == 2);
    buffer_end <= (k == 3);
    @(posedge clk);
    {xfer_src_done, xfer_dst_done, desc_load, buffer_end} <= 4'h0;
    dwb = act_m && k == 3;
    if (act_m && k < 2) mstep(k);
    if (act_m && k == 2)
    begin
      if (!ctrl_m[16]) ma[0] = desc_src_addr;
      if (!ctrl_m[20]) ma[1] = desc_dst_addr;
      if (desc_done_bit && cfg_m[16]) {act_m, ev_m[1]} = 2'b01;
      cnt = '{0, 0};
    end
    if (act_m && k == 3)
    begin
      if (!ctrl_m[30]) ev_m[0] = 1'b1;
      if (!ctrl_m[31]) act_m = 1'b0;
      if (ctrl_m[31] && cfg_m[8]) ma[0] = st_m[0];
      if (ctrl_m[31] && cfg_m[12]) ma[1] = st_m[1];
      cnt = '{0, 0};
    end
    #1 chk(done_writeback, dwb);
    chk(src_addr, ma[0]);
    chk(dst_addr, ma[1]);
    chk(chan_active, act_m);
    @(posedge clk);
  endtask
  task automatic fields;
    chk({dps, sps}, {ctrl_m[4], ctrl_m[0]});
    chk(flow, ctrl_m[22:21]);
    chk({dpn, spn}, cfg_m[7:0]);
    chk({dhs, shs}, {cfg_m[13], cfg_m[9]});
    chk({arb, bsl, ifl}, cfg_m[22:20]);
    chk(fifo, cfg_m[29:28]);
    chk(bus_protection_attributes, {cfg_m[26:24], 1'b1});
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    fields;
    rd(`DCC_OFF_CTRL_B, 32'h0);
    rd(32'hFFFFEC48, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      wr(`DCC_OFF_CTRL_B, {r[31:23], 2'(i), r[20:0]});
      wr(`DCC_OFF_CONFIG, {r[31:30], 2'(i % 3), r[27:0]});
      rd(`DCC_OFF_CTRL_B, ctrl_m);
      rd(`DCC_OFF_CONFIG, cfg_m);
      fields;
    end
    wr(`DCC_OFF_WP_MODE, {`DCC_WP_KEY, 8'h01});
    rd(`DCC_OFF_WP_MODE, 32'h1);
    wr(`DCC_OFF_CTRL_B, ~ctrl_m);
    wr(`DCC_OFF_CONFIG, ~cfg_m);
    wr(`DCC_OFF_WP_MODE, 32'h0);
    rd(`DCC_OFF_CTRL_B, ctrl_m);
    rd(`DCC_OFF_CONFIG, cfg_m);
    wr(`DCC_OFF_WP_MODE, {`DCC_WP_KEY, 8'h00});
    for (int m = 0; m < 3; m++)
    begin
      addr_step <= 3'(m + 2);
      r = $random(seed);
      wr(`DCC_OFF_SRC_START, r);
      wr(`DCC_OFF_DST_START, ~r);
      wr(`DCC_OFF_CTRL_B, {2'h0, 2'(m), 2'h0, 2'(m), 24'h0});
      wr(`DCC_OFF_CHANNEL, 32'h0);
      wr(`DCC_OFF_CHANNEL, 32'h1);
      repeat (2) ev(0);
      ev(1);
    end
    wr(`DCC_OFF_SRC_JUMP, 32'h00020010);
    wr(`DCC_OFF_DST_JUMP, 32'h00030020);
    wr(`DCC_OFF_CTRL_B, 32'h00001100);
    wr(`DCC_OFF_CHANNEL, 32'h0);
    wr(`DCC_OFF_CHANNEL, 32'h1);
    repeat (3) ev(0);
    repeat (4) ev(1);
    wr(`DCC_OFF_CTRL_B, 32'h00100000);
    desc_src_addr <= r ^ 32'h5A5A0000;
    desc_dst_addr <= r + 32'h100;
    desc_done_bit <= 1'b1;
    ev(2);
    wr(`DCC_OFF_CONFIG, 32'h00010000);
    ev(2);
    rd(`DCC_OFF_EVENT, {30'h0, ev_m});
    wr(`DCC_OFF_EVENT, 32'h3);
    wr(`DCC_OFF_CONFIG, 32'h00000100);
    wr(`DCC_OFF_CTRL_B, 32'h80000000);
    wr(`DCC_OFF_CHANNEL, 32'h1);
    ev(0);
    ev(1);
    ev(3);
    rd(`DCC_OFF_EVENT, {30'h0, ev_m});
    wr(`DCC_OFF_EVENT, 32'h1);
    wr(`DCC_OFF_CTRL_B, 32'h40000000);
    ev(3);
    rd(`DCC_OFF_EVENT, {30'h0, ev_m});
    ev(3);
    r = $random(seed);
    sel <= r[3:0];
    wr(`DCC_OFF_CONFIG, {16'h0, 8'h22, r[3:0], r[3:0]});
    wr(`DCC_OFF_CHANNEL, 32'h1);
    repeat (3) @(posedge clk);
    chk({dst_request, src_request}, 2'b00);
    lvl <= 1'b1;
    repeat (4) @(posedge clk);
    chk({dst_request, src_request}, 2'b11);
    wr(`DCC_OFF_CONFIG, 32'h000000FF);
    wr(`DCC_OFF_CHANNEL, 32'h7);
    chk({dst_request, src_request}, 2'b11);
    rd(`DCC_OFF_CHANNEL, 32'h00000307);
    close_out;
  end
endmodule

// file: hw/dcc_channel.sv
// One DMA channel: control B, configuration, address walk and request routing
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_channel #(
  parameter int NUM_PERIPH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic [NUM_PERIPH-1:0] periph_req,
  input wire logic xfer_src_done,
  input wire logic xfer_dst_done,
  input wire logic [2:0] addr_step,
  input wire logic desc_load,
  input wire logic [31:0] desc_src_addr,
  input wire logic [31:0] desc_dst_addr,
  input wire logic desc_done_bit,
  input wire logic buffer_end,
  output logic chan_active,
  output logic [31:0] src_addr,
  output logic [31:0] dst_addr,
  output logic source_port_select,
  output logic destination_port_select,
  output dcc_pkg::dcc_flow_e flow_controller_select,
  output logic [3:0] source_peripheral_number,
  output logic [3:0] destination_peripheral_number,
  output logic source_handshake_select,
  output logic destination_handshake_select,
  output logic src_request,
  output logic dst_request,
  output dcc_pkg::dcc_fifo_e fifo_service_policy,
  output logic [3:0] bus_protection_attributes,
  output logic if_lock_enable,
  output logic bus_lock_enable,
  output logic arb_lock_buffer,
  output logic buffer_complete_flag,
  output logic done_writeback
);
  import dcc_pkg::*;

  // Ids are four bits wide, so more lines than sixteen cannot be addressed
  if (NUM_PERIPH < 1 || NUM_PERIPH > 16)
  begin : g_bad_param
    $error("NUM_PERIPH must lie in 1..16");
  end

  logic [31:0] channel_control_b;
  logic [31:0] channel_configuration;
  logic [31:0] src_jump;
  logic [31:0] dst_jump;
  logic [31:0] src_start;
  logic [31:0] dst_start;
  logic write_protect_enable;
  logic stop_flag;
  logic sw_src_req;
  logic sw_dst_req;
  logic [NUM_PERIPH-1:0] req_s1;
  logic [NUM_PERIPH-1:0] req_s2;
  logic [15:0] req_wide;
  logic [9:0] src_cnt;
  logic [9:0] dst_cnt;
  logic src_hit;
  logic dst_hit;
  logic wr_open;
  logic start;
  logic run_end;
  logic sod_stop;

  // Address walk shared by both sides; mode 11 is reserved and holds
  function automatic logic [31:0] dcc_next_addr(input logic [31:0] a, input logic [1:0] m,
                                                input logic [2:0] s, input logic j, input logic [15:0] h);
    logic [31:0] r;
    r = a;
    unique case (m)
      DCC_ADDR_INC: r = a + {29'h0, s};
      DCC_ADDR_DEC: r = a - {29'h0, s};
      default: r = a;
    endcase
    if (j)
      r = r + {16'h0000, h};
    return r;
  endfunction

  // Boundary hit: the jump goes with the transfer that ends a row
  function automatic logic dcc_row_end(input logic en, input logic [9:0] cnt, input logic [9:0] bound);
    return en && (bound != 10'h000) && (cnt == bound - 10'h001);
  endfunction

  // Write protection shields only control B and configuration
  assign wr_open = bus_wr && !write_protect_enable;
  assign start = bus_wr && (bus_addr == `DCC_OFF_CHANNEL) && bus_wdata[0] && !chan_active;
  assign sod_stop = desc_load && chan_active && desc_done_bit
                    && channel_configuration[`DCC_C_STOP_DONE];
  assign run_end = buffer_end && chan_active && !channel_control_b[`DCC_B_AUTO];

  assign src_hit = dcc_row_end(channel_control_b[`DCC_B_SRC_JUMP], src_cnt,
                               src_jump[`DCC_J_BOUND]);
  assign dst_hit = dcc_row_end(channel_control_b[`DCC_B_DST_JUMP], dst_cnt,
                               dst_jump[`DCC_J_BOUND]);

  // Control B register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      channel_control_b <= `DCC_CTRL_B_RESET;
    end
    else if (ce && wr_open && bus_addr == `DCC_OFF_CTRL_B)
    begin
      channel_control_b <= bus_wdata & `DCC_CTRL_B_MASK;
    end
  end

  // Configuration register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      channel_configuration <= `DCC_CONFIG_RESET;
    end
    else if (ce && wr_open && bus_addr == `DCC_OFF_CONFIG)
    begin
      channel_configuration <= bus_wdata & `DCC_CONFIG_MASK;
    end
  end

  // Start addresses and window jump registers stay writable always
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      src_start <= 32'h00000000;
      dst_start <= 32'h00000000;
      src_jump <= 32'h00000000;
      dst_jump <= 32'h00000000;
    end
    else if (ce && bus_wr)
    begin
      if (bus_addr == `DCC_OFF_SRC_START)
        src_start <= bus_wdata;
      if (bus_addr == `DCC_OFF_DST_START)
        dst_start <= bus_wdata;
      if (bus_addr == `DCC_OFF_SRC_JUMP)
        src_jump <= bus_wdata & `DCC_JUMP_MASK;
      if (bus_addr == `DCC_OFF_DST_JUMP)
        dst_jump <= bus_wdata & `DCC_JUMP_MASK;
    end
  end

  // Protection enable changes only with the right key, so stray writes cannot unlock
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      write_protect_enable <= 1'b0;
    else if (ce && bus_wr && bus_addr == `DCC_OFF_WP_MODE
             && bus_wdata[31:8] == `DCC_WP_KEY)
      write_protect_enable <= bus_wdata[0];
  end

  // Channel run state; a software write lands after hardware stops and so wins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      chan_active <= 1'b0;
    end
    else if (ce)
    begin
      if (sod_stop || run_end)
      begin
        chan_active <= 1'b0;
      end
      if (bus_wr && bus_addr == `DCC_OFF_CHANNEL)
      begin
        chan_active <= bus_wdata[0];
      end
    end
  end

  // Software handshake requests: set by write, dropped when the side moves data unless a channel write lands in the same cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sw_src_req <= 1'b0;
      sw_dst_req <= 1'b0;
    end
    else if (ce)
    begin
      if (xfer_src_done || !chan_active)
      begin
        sw_src_req <= 1'b0;
      end
      if (xfer_dst_done || !chan_active)
      begin
        sw_dst_req <= 1'b0;
      end
      if (bus_wr && bus_addr == `DCC_OFF_CHANNEL)
      begin
        sw_src_req <= sw_src_req | bus_wdata[1];
        sw_dst_req <= sw_dst_req | bus_wdata[2];
      end
    end
  end

  // Event flags: a set in the same cycle as a clear is kept
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      buffer_complete_flag <= 1'b0;
      stop_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (buffer_end && chan_active && !channel_control_b[`DCC_B_SUPPRESS])
        buffer_complete_flag <= 1'b1;
      else if (bus_wr && bus_addr == `DCC_OFF_EVENT && bus_wdata[0])
        buffer_complete_flag <= 1'b0;
      if (sod_stop)
        stop_flag <= 1'b1;
      else if (bus_wr && bus_addr == `DCC_OFF_EVENT && bus_wdata[1])
        stop_flag <= 1'b0;
    end
  end

  // Done write-back request, one cycle per finished descriptor
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      done_writeback <= 1'b0;
    end
    else if (ce)
    begin
      done_writeback <= buffer_end && chan_active;
    end
  end

  // Source address: start, descriptor, reload, then per-transfer walk
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      src_addr <= 32'h00000000;
    end
    else if (ce)
    begin
      if (start)
        src_addr <= src_start;
      else if (desc_load && chan_active && !channel_control_b[`DCC_B_SRC_SKIP])
        src_addr <= desc_src_addr;
      else if (buffer_end && chan_active && channel_control_b[`DCC_B_AUTO]
               && channel_configuration[`DCC_C_SRC_RELOAD])
        src_addr <= src_start;
      else if (xfer_src_done && chan_active)
        src_addr <= dcc_next_addr(src_addr, channel_control_b[`DCC_B_SRC_MODE],
                                  addr_step, src_hit, src_jump[`DCC_J_HOLE]);
    end
  end

  // Destination address, same order of precedence
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dst_addr <= 32'h00000000;
    end
    else if (ce)
    begin
      if (start)
        dst_addr <= dst_start;
      else if (desc_load && chan_active && !channel_control_b[`DCC_B_DST_SKIP])
        dst_addr <= desc_dst_addr;
      else if (buffer_end && chan_active && channel_control_b[`DCC_B_AUTO]
               && channel_configuration[`DCC_C_DST_RELOAD])
        dst_addr <= dst_start;
      else if (xfer_dst_done && chan_active)
        dst_addr <= dcc_next_addr(dst_addr, channel_control_b[`DCC_B_DST_MODE],
                                  addr_step, dst_hit, dst_jump[`DCC_J_HOLE]);
    end
  end

  // Row counters restart with each channel start and each new buffer
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      src_cnt <= 10'h000;
      dst_cnt <= 10'h000;
    end
    else if (ce)
    begin
      if (start || buffer_end || desc_load)
      begin
        src_cnt <= 10'h000;
        dst_cnt <= 10'h000;
      end
      else
      begin
        if (xfer_src_done && chan_active)
        begin
          src_cnt <= src_hit ? 10'h000 : src_cnt + 10'h001;
        end
        if (xfer_dst_done && chan_active)
        begin
          dst_cnt <= dst_hit ? 10'h000 : dst_cnt + 10'h001;
        end
      end
    end
  end

  // Peripheral request lines are asynchronous pins: two flops first
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      req_s1 <= '0;
      req_s2 <= '0;
    end
    else if (ce)
    begin
      req_s1 <= periph_req;
      req_s2 <= req_s1;
    end
  end

  // Unused identifiers read as no request
  for (genvar g = 0; g < 16; g++)
  begin : g_req
    if (g < NUM_PERIPH)
    begin : g_on
      assign req_wide[g] = req_s2[g];
    end
    else
    begin : g_off
      assign req_wide[g] = 1'b0;
    end
  end

  // Request routing by handshake kind and peripheral number
  assign src_request = chan_active && (source_handshake_select
                       ? req_wide[source_peripheral_number] : sw_src_req);
  assign dst_request = chan_active && (destination_handshake_select
                       ? req_wide[destination_peripheral_number] : sw_dst_req);

  // Straight field outputs; all come from register flops
  assign source_port_select = channel_control_b[`DCC_B_SRC_PORT];
  assign destination_port_select = channel_control_b[`DCC_B_DST_PORT];
  assign flow_controller_select = dcc_flow_e'(channel_control_b[`DCC_B_FLOW]);
  assign source_peripheral_number = channel_configuration[`DCC_C_SOURCE_PERIPHERAL_NUMBER];
  assign destination_peripheral_number = channel_configuration[`DCC_C_DESTINATION_PERIPHERAL_NUMBER];
  assign source_handshake_select = channel_configuration[`DCC_C_SRC_HS];
  assign destination_handshake_select = channel_configuration[`DCC_C_DST_HS];
  assign if_lock_enable = channel_configuration[`DCC_C_IF_LOCK];
  assign bus_lock_enable = channel_configuration[`DCC_C_BUS_LOCK];
  assign arb_lock_buffer = channel_configuration[`DCC_C_ARB_BUF];
  assign fifo_service_policy = dcc_fifo_e'(channel_configuration[`DCC_C_FIFO]);
  // Bit 0 marks a data access and is never cleared
  assign bus_protection_attributes = {channel_configuration[`DCC_C_PROT], 1'b1};

  // Read port: data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bus_rdata <= 32'h00000000;
    end
    else if (ce)
    begin
      bus_rdata <= 32'h00000000;
      if (bus_rd)
      begin
        unique case (bus_addr)
          `DCC_OFF_SRC_START: bus_rdata <= src_start;
          `DCC_OFF_DST_START: bus_rdata <= dst_start;
          `DCC_OFF_CTRL_B: bus_rdata <= channel_control_b;
          `DCC_OFF_CONFIG: bus_rdata <= channel_configuration;
          `DCC_OFF_SRC_JUMP: bus_rdata <= src_jump;
          `DCC_OFF_DST_JUMP: bus_rdata <= dst_jump;
          `DCC_OFF_CHANNEL: bus_rdata <= {22'h000000, dst_request, src_request,
                                          5'h00, sw_dst_req, sw_src_req, chan_active};
          `DCC_OFF_EVENT: bus_rdata <= {30'h00000000, stop_flag, buffer_complete_flag};
          `DCC_OFF_WP_MODE: bus_rdata <= {31'h00000000, write_protect_enable};
          default: bus_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// file: hw/dcc_defines.svh
// Register map, field positions, reset values and keys for the channel control block
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
`define DCC_OFF_SRC_START 32'hFFFFEC40
`define DCC_OFF_DST_START 32'hFFFFEC44
`define DCC_OFF_CTRL_B 32'hFFFFEC4C
`define DCC_OFF_CONFIG 32'hFFFFEC50
`define DCC_OFF_SRC_JUMP 32'hFFFFEC54
`define DCC_OFF_DST_JUMP 32'hFFFFEC58
`define DCC_OFF_CHANNEL 32'hFFFFEC60
`define DCC_OFF_EVENT 32'hFFFFEC64
`define DCC_OFF_WP_MODE 32'hFFFFEDE4
`define DCC_CTRL_B_MASK 32'hF3711111
`define DCC_CONFIG_MASK 32'h377133FF
`define DCC_JUMP_MASK 32'h03FFFFFF
`define DCC_CTRL_B_RESET 32'h00000000
`define DCC_CONFIG_RESET 32'h00000000
`define DCC_WP_KEY 24'h444D41
`define DCC_B_SRC_PORT 0
`define DCC_B_DST_PORT 4
`define DCC_B_SRC_JUMP 8
`define DCC_B_DST_JUMP 12
`define DCC_B_SRC_SKIP 16
`define DCC_B_DST_SKIP 20
`define DCC_B_FLOW 22:21
`define DCC_B_SRC_MODE 25:24
`define DCC_B_DST_MODE 29:28
`define DCC_B_SUPPRESS 30
`define DCC_B_AUTO 31
`define DCC_C_SOURCE_PERIPHERAL_NUMBER 3:0
`define DCC_C_DESTINATION_PERIPHERAL_NUMBER 7:4
`define DCC_C_SRC_RELOAD 8
`define DCC_C_SRC_HS 9
`define DCC_C_DST_RELOAD 12
`define DCC_C_DST_HS 13
`define DCC_C_STOP_DONE 16
`define DCC_C_IF_LOCK 20
`define DCC_C_BUS_LOCK 21
`define DCC_C_ARB_BUF 22
`define DCC_C_PROT 26:24
`define DCC_C_FIFO 29:28
`define DCC_J_HOLE 15:0
`define DCC_J_BOUND 25:16
`endif

// file: hw/dcc_pkg.sv
// Types shared by the channel control block
package dcc_pkg;
  typedef enum logic [1:0] {
    DCC_ADDR_INC = 2'h0,
    DCC_ADDR_DEC = 2'h1,
    DCC_ADDR_FIX = 2'h2
  } dcc_addr_mode_e;
  typedef enum logic [1:0] {
    DCC_FLOW_M2M = 2'h0,
    DCC_FLOW_M2P = 2'h1,
    DCC_FLOW_P2M = 2'h2,
    DCC_FLOW_P2P = 2'h3
  } dcc_flow_e;
  typedef enum logic [1:0] {
    DCC_FIFO_LONGEST = 2'h0,
    DCC_FIFO_HALF = 2'h1,
    DCC_FIFO_SINGLE = 2'h2
  } dcc_fifo_e;
endpackage
